// ---- tb/ecg_frame_serial_port_checker.sv ----
// Port checker of the ECG frame serial port, bound to the top module.
// Assumes a 200 MHz clk and host sclk phases of at least four clk.
`timescale 1ns/1ps
module ecg_frame_serial_port_checker (
   input wire        clk,
   input wire        arst_n,
   input wire        cs_n,
   input wire        sclk,
   input wire        sdo,
   input wire        sdo_oe,
   input wire        frame_ready_n,
   input wire [6:0]  rd_addr,
   input wire        wr_strobe,
   input wire [6:0]  wr_addr,
   input wire [23:0] wr_data,
   input wire        conversions_enabled,
   input wire        frame_loaded,
   input wire        frame_streaming
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   reg  [2:0] up_q; // Edges since release
   wire       ok = (up_q == 3'h7); // Internal reset and syncs are over
   // Count out the two-flop release before judging lagged outputs
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) up_q <= 3'h0;
      else if (!ok) up_q <= up_q + 3'h1;
   end
   ////////////////////////////////////////////////////////////////////
   // Four edges outlast the pin synchroniser lag
   sequence s_cs_idle; cs_n [*4]; endsequence
   sequence s_cs_busy; ok && !cs_n [*4]; endsequence
   property p_oe_off; s_cs_idle |-> !sdo_oe; endproperty
   a_oe_off: assert property (p_oe_off) else $error("sdo driven while deselected");
   property p_oe_on; s_cs_busy |-> sdo_oe; endproperty
   a_oe_on: assert property (p_oe_on) else $error("sdo not driven while selected");
   property p_rdy_off; (ok && !conversions_enabled) [*3] |-> !frame_ready_n; endproperty
   a_rdy_off: assert property (p_rdy_off) else $error("ready high with framing off");
   property p_rdy_set;
      $fell(frame_ready_n) && conversions_enabled && $past(conversions_enabled, 3)
      |-> $past(frame_loaded) || $past(frame_loaded, 2) || $past(frame_loaded, 3);
   endproperty
   a_rdy_set: assert property (p_rdy_set) else $error("ready without a loaded frame");
   property p_wr_pulse; wr_strobe |=> !wr_strobe; endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
   property p_wr_nop; wr_strobe |-> wr_addr != 7'h00; endproperty
   a_wr_nop: assert property (p_wr_nop) else $error("no-op word committed");
   property p_wr_hold; ok && wr_strobe |-> $stable(wr_addr) && $stable(wr_data); endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write data moved at commit");
   // Output may only move a few clk after a pin fall
   property p_sdo_fall;
      ok && sdo_oe && $past(sdo_oe) && $changed(sdo) |-> !($past(sclk) && $past(sclk, 2)
      && $past(sclk, 3) && $past(sclk, 4) && $past(sclk, 5));
   endproperty
   a_sdo_fall: assert property (p_sdo_fall) else $error("sdo moved away from a fall");
   property p_stream_go; $rose(frame_streaming) |-> rd_addr == 7'h40 || $past(rd_addr) == 7'h40;
   endproperty
   a_stream_go: assert property (p_stream_go) else $error("stream began off header");
endmodule
bind ecg_frame_serial_port ecg_frame_serial_port_checker i_chk (.clk(clk), .arst_n(arst_n),
   .cs_n(cs_n), .sclk(sclk), .sdo(sdo), .sdo_oe(sdo_oe), .frame_ready_n(frame_ready_n),
   .rd_addr(rd_addr), .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
   .conversions_enabled(conversions_enabled), .frame_loaded(frame_loaded),
   .frame_streaming(frame_streaming));

// ---- tb/ecg_host_model.sv ----
// Host serial master: drives cs_n, sclk and sdi, reads the resolved sdo.
// Assumes a 200 MHz clk; one sclk period is 10 clk, 20 MHz.
`timescale 1ns/1ps
module ecg_host_model (
   input  wire clk,
   output reg  cs_n,
   output reg  sclk,
   output reg  sdi,
   input  wire sdo_line
);
   // Idle: deselected, clock parked high
   initial begin
      cs_n = 1'b1;
      sclk = 1'b1;
      sdi  = 1'b1;
   end
   // One word MSB first; 20 MHz stays under every SCLK ceiling
   // Gap after the word lets the handshake finish
   task xfer(input integer nb, input [31:0] w, input keep, input integer gap,
             output logic [31:0] r);
      integer i;
      begin
         r = 32'h0;
         cs_n <= 1'b0;
         repeat (4) @(posedge clk);
         for (i = nb - 1; i >= 0; i = i - 1) begin
            sclk <= 1'b0;
            sdi  <= w[i];
            repeat (6) @(posedge clk);
            r = {r[30:0], sdo_line};
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
         end
         // Released data line shows the inverse, not a stale bit
         sdi <= ~w[0];
         if (!keep) cs_n <= 1'b1;
         repeat (gap) @(posedge clk);
      end
   endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench of the ECG frame serial port.
// Host model drives the pins; the bench stands in for the register core.
`timescale 1ns/1ps
module tb_top;
   reg         clk, arst_n, hps, conv, loaded;
   reg  [1:0]  rate, skip;
   reg  [11:0] mask;
   reg  [23:0] salt;
   reg  [31:0] seed, r;
   reg  [30:0] wlast;   // Last committed address and data
   wire        sdo, sdo_oe, ready_n, wr_strobe, streaming, cs_n, sclk, sdi;
   wire [6:0]  rd_addr, wr_addr;
   wire [23:0] rd_data, wr_data;
   wire        sdo_line = sdo_oe ? sdo : 1'bz; // Released line floats
   integer     n_errors = 0, compares = 0, wr_cnt = 0;
   reg  [31:0] exp_q [$];
   localparam [83:0] SLOTS = {7'h41, 7'h06, 7'h1d, 7'h1c, 7'h1b, 7'h1a,
                              7'h15, 7'h14, 7'h13, 7'h12, 7'h11, 7'h40};
   // Core register contents: address pattern scrambled by a random salt
   function [23:0] core(input [6:0] a);
      core = {a, a[3:0], a, a[5:0]} ^ salt;
   endfunction
   function [31:0] lfsr(input [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Written out so a salt change alone also updates the read data
   assign rd_data = {rd_addr, rd_addr[3:0], rd_addr, rd_addr[5:0]} ^ salt;
   ecg_frame_serial_port i_ecg_frame_serial_port (.clk(clk), .arst_n(arst_n), .cs_n(cs_n),
      .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .frame_ready_n(ready_n),
      .rd_addr(rd_addr), .rd_data(rd_data), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
      .wr_data(wr_data), .frame_rate_sel(rate), .high_performance_select(hps),
      .conversions_enabled(conv), .frame_word_enable(mask), .frame_skip(skip),
      .frame_loaded(loaded), .frame_streaming(streaming));
   ecg_host_model i_ecg_host_model (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
      .sdo_line(sdo_line));
   ////////////////////////////////////////////////////////////////////
   // Record every committed write
   always @(posedge clk) begin
      if (wr_strobe === 1'b1) begin
         wr_cnt <= wr_cnt + 1;
         wlast  <= {wr_addr, wr_data};
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("compares=%0d n_errors=%0d", compares, n_errors);
         if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   // One-cycle new-frame pulse from the core, then settle
   task pulse;
      begin
         loaded <= 1'b1;
         @(posedge clk) loaded <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
   // Expected frame from the mask, then read it with zero words
   task stream(input [11:0] m, input short, input [31:0] last_cmd);
      integer n, k, nb;
      reg [23:0] d;
      begin
         exp_q.delete();
         for (k = 0; k < 12; k = k + 1) begin
            d = core(SLOTS[k*7 +: 7]);
            if (m[k] && !short) exp_q.push_back({1'b0, SLOTS[k*7 +: 7], d});
            if (m[k] && short) exp_q.push_back(d[23:8]);
            if (m[k] && short && k >= 6 && k <= 8) exp_q.push_back({d[7:0], 8'h00});
         end
         mask <= m;
         rate <= short ? 2'h2 : {1'b0, seed[0]};
         @(posedge clk);
         n = exp_q.size();
         i_ecg_host_model.xfer(32, 32'h40000000, 1'b1, 400, r);
         chk(streaming, 1);
         for (k = 0; k < n; k = k + 1) begin
            nb = (short && k != n - 1) ? 16 : 32;
            // Last word carries the breaking command
            i_ecg_host_model.xfer(nb, (k == n - 1) ? last_cmd : 32'h0, k[0], 400, r);
            chk(short ? r >> (nb - 16) : r, exp_q.pop_front());
         end
         i_ecg_host_model.xfer(32, 32'h0, 1'b0, 400, r);
         chk(streaming, 0);
         if (!last_cmd[31]) chk(r, {1'b0, last_cmd[30:24], core(last_cmd[30:24])});
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Hang guard: well beyond the expected run of about 46k clk
   initial begin
      repeat (90000) @(posedge clk);
      n_errors = n_errors + 1;
      give_verdict;
   end
   initial begin
      arst_n = 1'b0;
      hps = 1'b1;
      conv = 1'b0;
      loaded = 1'b0;
      rate = 2'h0;
      skip = 2'h0;
      mask = 12'heff;
      seed = 32'h9163;
      salt = 24'h0;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      repeat (8) @(posedge clk);
      chk(ready_n, 0);
      chk(sdo_oe, 0);
      seed = lfsr(seed);
      salt <= seed[31:8];
      i_ecg_host_model.xfer(32, {1'b1, 7'h06, seed[23:0]}, 1'b0, 20, r);
      chk(wlast, {7'h06, seed[23:0]});
      i_ecg_host_model.xfer(32, {1'b1, 7'h1d, ~seed[23:0]}, 1'b1, 20, r);
      i_ecg_host_model.xfer(32, 32'h0, 1'b0, 20, r);
      chk(wlast, {7'h1d, ~seed[23:0]});
      chk(wr_cnt, 2);
      // Back-to-back reads answer one word late
      i_ecg_host_model.xfer(32, 32'h11000000, 1'b0, 20, r);
      i_ecg_host_model.xfer(32, 32'h06000000, 1'b0, 20, r);
      chk(r, {1'b0, 7'h11, core(7'h11)});
      i_ecg_host_model.xfer(32, 32'h0, 1'b0, 20, r);
      chk(r, {1'b0, 7'h06, core(7'h06)});
      conv <= 1'b1;
      repeat (4) @(posedge clk);
      chk(ready_n, 1);
      pulse;
      chk(ready_n, 0);
      stream(12'heff, 1'b0, 32'h12000000);
      chk(ready_n, 1);
      stream(12'hfff, 1'b0, 32'h1d000000);
      // One frame dropped between kept ones
      skip <= 2'h1;
      pulse;
      chk(ready_n, 1);
      pulse;
      chk(ready_n, 0);
      seed = lfsr(seed);
      hps <= 1'b0;
      stream(seed[11:0] | 12'h001, 1'b0, 32'h06000000);
      hps <= 1'b1;
      stream(12'heff, 1'b1, 32'h86123456);
      stream(12'hfff, 1'b1, 32'h86654321);
      chk(wlast, {7'h06, 24'h654321});
      chk(wr_cnt, 4);
      give_verdict;
   end
endmodule

// ---- verilog/ecg_frame_serial_port.v ----
// Serial slave port of the ECG acquisition device: command words, register
// read responses and frame streaming. Assumes cs_n/sclk/sdi arrive as
// asynchronous pins; register data is served by the core on rd_addr/rd_data.
// Function
// - Bit 31 R/W, 30:24 address, 23:0 data
// - Commit write at CS rise or next word
// - Read data shifts out during next word
// - 128 kHz frame words: 16-bit upper halves
// - Slow-rate frame words carry address top byte
// - Read of 0x40 starts frame streaming
// - All-zero words keep frames flowing
// - CS may toggle per word or stay low
// - Default frame: 11 long or 13 short
// - Full frame: 12 long or 15 short
// - Frame control mask selects frame words
// - Register read stops streaming until 0x40
// - Ordinary reads are 32 bits, MSB first
// - Internal clock 2.048 or 1.024 MHz
// - Word handshake takes three internal cycles
// - Frame skipping lowers output rate
// - Fixed frame word order by address
// - Wide words take two short slots
// - Sample on rise, shift out on fall
// - CS high: ignore input, release output
// - Ready low when frame buffered
`timescale 1ns/1ps
`include "ecg_frame_serial_port_defs.vh"

module ecg_frame_serial_port (
   input  wire        clk,                     // 200 MHz system clock
   input  wire        arst_n,                  // Asynchronous reset, active low
   input  wire        cs_n,                    // Chip select pin
   input  wire        sclk,                    // Serial clock pin
   input  wire        sdi,                     // Serial data in pin
   output reg         sdo,                     // Serial data out level
   output reg         sdo_oe,                  // Serial data out enable
   output reg         frame_ready_n,           // Frame ready, active low
   output reg  [6:0]  rd_addr,                 // Register address to the core
   input  wire [23:0] rd_data,                 // Register contents from the core
   output reg         wr_strobe,               // One-cycle register write pulse
   output reg  [6:0]  wr_addr,                 // Write address
   output reg  [23:0] wr_data,                 // Write data
   input  wire [1:0]  frame_rate_sel,          // Frame rate code
   input  wire        high_performance_select, // Internal clock doubled
   input  wire        conversions_enabled,     // Framing enabled
   input  wire [11:0] frame_word_enable,       // Frame membership mask
   input  wire [1:0]  frame_skip,              // Frames dropped between kept ones
   input  wire        frame_loaded,            // Core pulse: new frame computed
   output reg         frame_streaming          // Streaming mode active
);

   ////////////////////////////////////////////////////////////////////////////
   // Constants and functions
   // Internal clock dividers, rounded down so a tick is never late
   localparam integer DIV_LOW  = (`CLK_HZ / `MCLK_BASE_HZ) - 1;
   localparam integer DIV_HIGH = (`CLK_HZ / (2 * `MCLK_BASE_HZ)) - 1;

   // Address of each frame slot in transmit order
   function [6:0] slot_addr;
      input [3:0] s;
      begin
         case (s)
            4'h0:    slot_addr = `ADDR_FRAME_START;
            4'h1:    slot_addr = `ADDR_CHANNEL_ONE;
            4'h2:    slot_addr = `ADDR_CHANNEL_TWO;
            4'h3:    slot_addr = `ADDR_CHANNEL_THR;
            4'h4:    slot_addr = `ADDR_CHANNEL_FOU;
            4'h5:    slot_addr = `ADDR_CHANNEL_FIV;
            4'h6:    slot_addr = `ADDR_PACING;
            4'h7:    slot_addr = `ADDR_BREATH_MAG;
            4'h8:    slot_addr = `ADDR_BREATH_PHASE;
            4'h9:    slot_addr = `ADDR_DETACH;
            4'ha:    slot_addr = `ADDR_PIN_LEVELS;
            4'hb:    slot_addr = `ADDR_FRAME_CHECK;
            default: slot_addr = `ADDR_NO_OPERATION;
         endcase
      end
   endfunction
   // First enabled slot at or after s; SLOT_COUNT when none
   function [3:0] next_slot;
      input [3:0]  s;
      input [11:0] m;
      integer      i;
      reg          found;
      begin
         next_slot = `SLOT_COUNT;
         found     = 1'b0;
         for (i = 0; i < 12; i = i + 1) begin
            if (!found && (i >= s) && m[i]) begin
               next_slot = i[3:0];
               found     = 1'b1;
            end
         end
      end
   endfunction
   // Pacing, breathing magnitude and phase span two short words
   function is_wide;
      input [3:0] s;
      begin
         is_wide = (s >= `SLOT_PACING) && (s <= `SLOT_BREATH_PHASE);
      end
   endfunction
   // Shape an outgoing word; short words sit in the top half
   function [31:0] fmt;
      input [6:0]  a;
      input [23:0] d;
      input        short;
      input        lower;
      begin
         if (!short)
            fmt = {1'b0, a, d};
         else if (lower)
            fmt = {d[7:0], 8'h00, 16'h0000};
         else
            fmt = {d[23:8], 16'h0000};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Reset release and pin synchronisers
   reg        rst_meta_q;   // Reset release, first stage
   reg        rst_n_q;      // Reset copy used by the design
   reg        cs_meta_q;    // Chip select, first stage
   reg        cs_q;         // Chip select, synchronised
   reg        cs_prev_q;    // Chip select, one cycle older
   reg        sclk_meta_q;  // Serial clock, first stage
   reg        sclk_q;       // Serial clock, synchronised
   reg        sclk_prev_q;  // Serial clock, one cycle older
   reg        sdi_meta_q;   // Serial input, first stage
   reg        sdi_q;        // Serial input, synchronised

   // Reset asserts at once and releases after two edges
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // Pins pass two flops; SCLK idles high, so reset to high
   always @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cs_meta_q   <= 1'b1;
         cs_q        <= 1'b1;
         cs_prev_q   <= 1'b1;
         sclk_meta_q <= 1'b1;
         sclk_q      <= 1'b1;
         sclk_prev_q <= 1'b1;
         sdi_meta_q  <= 1'b0;
         sdi_q       <= 1'b0;
      end else begin
         cs_meta_q   <= cs_n;
         cs_q        <= cs_meta_q;
         cs_prev_q   <= cs_q;
         sclk_meta_q <= sclk;
         sclk_q      <= sclk_meta_q;
         sclk_prev_q <= sclk_q;
         sdi_meta_q  <= sdi;
         sdi_q       <= sdi_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial state
   reg [31:0] rx_q;         // Receive shift register
   reg [5:0]  cnt_q;        // Bits taken in the current word
   reg [31:0] tx_q;         // Transmit shift register
   reg        load_q;       // Load tx from rd_data this cycle
   reg        stream_q;     // Frame streaming mode
   reg [3:0]  slot_q;       // Frame slot to send next
   reg        half_q;       // Second half of a wide slot
   reg        full_q;       // Frame buffer holds an unread frame
   reg        last_tx_q;    // Last frame word is being sent
   reg [1:0]  skip_q;       // Loaded frames dropped so far
   reg        wr_pend_q;    // Write taken, awaiting commit
   reg [7:0]  div_q;        // Internal clock divider
   reg        hs_busy_q;    // Slot advance handshake running
   reg [1:0]  hs_cnt_q;     // Internal ticks seen in handshake

   // Edges are only seen while selected, so CS high ignores SDI
   wire        sel        = ~cs_q;
   wire        rise       = sel & sclk_q & ~sclk_prev_q;
   wire        fall       = sel & ~sclk_q & sclk_prev_q;
   wire        cs_rise    = cs_q & ~cs_prev_q;
   wire        fast       = (frame_rate_sel == `RATE_128K);
   wire        short_mode = stream_q & fast;
   wire [31:0] rx_next    = {rx_q[30:0], sdi_q};
   // A 16-bit zero word in short streaming is a keep-going word
   wire        done_short = rise & short_mode & (cnt_q == `LAST_BIT_SHORT)
                            & (rx_next[15:0] == 16'h0000);
   wire        done_long  = rise & (cnt_q == `LAST_BIT_LONG);
   wire        done       = done_short | done_long;
   wire [6:0]  cmd_addr   = rx_next[`CMD_ADDR_HI:`CMD_ADDR_LO];
   wire        cmd_read   = (rx_next[`CMD_RW_BIT] == `CMD_READ);
   wire        cmd_idle   = done_short | (cmd_addr == `ADDR_NO_OPERATION);
   wire        split      = fast & is_wide(slot_q) & ~half_q;
   wire [3:0]  slot_after = next_slot(slot_q + 4'h1, frame_word_enable);
   wire [3:0]  first_slot = next_slot(4'h0, frame_word_enable);
   wire [3:0]  wrap_slot  = (slot_after == `SLOT_COUNT) ? first_slot : slot_after;
   wire        last_word  = (slot_after == `SLOT_COUNT) & ~split;
   wire        tick       = (div_q == 8'h00);
   wire        hs_done    = hs_busy_q & tick & (hs_cnt_q == `HS_TICKS - 2'h1);

   ////////////////////////////////////////////////////////////////////////////
   // Internal clock tick, 1.024 or 2.048 MHz
   always @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q)
         div_q <= 8'h00;
      else if (tick)
         div_q <= high_performance_select ? DIV_HIGH[7:0] : DIV_LOW[7:0];
      else
         div_q <= div_q - 8'h01;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive side: bit count, command capture and write commit
   always @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rx_q      <= 32'h00000000;
         cnt_q     <= 6'h00;
         wr_pend_q <= 1'b0;
         wr_strobe <= 1'b0;
         wr_addr   <= 7'h00;
         wr_data   <= 24'h000000;
      end else begin
         // A CS rise aborts any partial word
         if (cs_rise || done)
            cnt_q <= 6'h00;
         else if (rise)
            cnt_q <= cnt_q + 6'h01;
         if (rise)
            rx_q <= rx_next;
         // Commit on CS rise or first SCLK rise of the next word
         wr_strobe <= wr_pend_q & (cs_rise | rise);
         if (done_long && !cmd_read && (cmd_addr != `ADDR_NO_OPERATION)) begin
            wr_pend_q <= 1'b1;
            wr_addr   <= cmd_addr;
            wr_data   <= rx_next[23:0];
         end else if (cs_rise || rise) begin
            wr_pend_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Word dispatch, frame slot walk and handshake
   always @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         stream_q  <= 1'b0;
         slot_q    <= 4'h0;
         half_q    <= 1'b0;
         rd_addr   <= `ADDR_NO_OPERATION;
         load_q    <= 1'b0;
         hs_busy_q <= 1'b0;
         hs_cnt_q  <= 2'h0;
         last_tx_q <= 1'b0;
      end else begin
         load_q <= 1'b0;
         // Slot advance waits three internal ticks, as the core would
         if (hs_busy_q && tick) begin
            hs_cnt_q <= hs_cnt_q + 2'h1;
         end
         if (hs_done) begin
            hs_busy_q <= 1'b0;
            hs_cnt_q  <= 2'h0;
            if (split) begin
               half_q <= 1'b1;
            end else begin
               half_q  <= 1'b0;
               slot_q  <= wrap_slot;
               rd_addr <= slot_addr(wrap_slot);
            end
         end
         if (done) begin
            last_tx_q <= 1'b0;
            if (stream_q && cmd_idle) begin
               // Keep streaming: the current slot goes out now
               hs_busy_q <= 1'b1;
               hs_cnt_q  <= 2'h0;
               last_tx_q <= last_word;
            end else if (cmd_read && (cmd_addr == `ADDR_FRAME_START)) begin
               stream_q  <= 1'b1;
               slot_q    <= first_slot;
               half_q    <= 1'b0;
               rd_addr   <= slot_addr(first_slot);
               load_q    <= 1'b1;
               hs_busy_q <= 1'b1;
               hs_cnt_q  <= 2'h0;
            end else if (cmd_read && !cmd_idle) begin
               stream_q  <= 1'b0;
               rd_addr   <= cmd_addr;
               load_q    <= 1'b1;
               hs_busy_q <= 1'b0;
            end else if (!cmd_idle) begin
               stream_q  <= 1'b0;
               hs_busy_q <= 1'b0;
            end
         end else if (cs_rise) begin
            last_tx_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit side: load, shift on falling SCLK, release when deselected
   always @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         tx_q   <= 32'h00000000;
         sdo    <= 1'b0;
         sdo_oe <= 1'b0;
      end else begin
         sdo_oe <= sel;
         if (load_q) begin
            // Response or first frame word, read one cycle after addressing
            tx_q <= fmt(rd_addr, rd_data, short_mode, half_q);
            sdo  <= 1'b0;
         end else if (done) begin
            if (stream_q && cmd_idle)
               tx_q <= fmt(rd_addr, rd_data, short_mode, half_q);
            else
               tx_q <= 32'h00000000;
            sdo <= 1'b0;
         end else if (fall) begin
            // First fall of a word shows the MSB, later falls shift
            if (cnt_q == 6'h00) begin
               sdo <= tx_q[31];
            end else begin
               sdo  <= tx_q[30];
               tx_q <= {tx_q[30:0], 1'b0};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame buffer state, frame skipping and ready output
   always @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         full_q          <= 1'b0;
         skip_q          <= 2'h0;
         frame_ready_n   <= 1'b1;
         frame_streaming <= 1'b0;
      end else begin
         frame_streaming <= stream_q;
         // A new frame wins over the clear in the same cycle
         if (frame_loaded && conversions_enabled && (skip_q == frame_skip)) begin
            full_q <= 1'b1;
            skip_q <= 2'h0;
         end else begin
            if (frame_loaded && conversions_enabled)
               skip_q <= skip_q + 2'h1;
            if (last_tx_q && (done || cs_rise))
               full_q <= 1'b0;
         end
         // Busy while empty with framing on; ready for commands otherwise
         frame_ready_n <= conversions_enabled ? ~full_q : 1'b0;
      end
   end
endmodule

// ---- verilog/ecg_frame_serial_port_defs.vh ----
// Constants of the ECG frame serial port: word fields, register addresses,
// frame slot order and timing. Definitions only, included by bare name.
`ifndef ECG_FRAME_SERIAL_PORT_DEFS_VH
`define ECG_FRAME_SERIAL_PORT_DEFS_VH

// Command word fields
`define CMD_RW_BIT        31
`define CMD_ADDR_HI       30
`define CMD_ADDR_LO       24
`define CMD_READ          1'b0
`define LAST_BIT_LONG     6'h1f
`define LAST_BIT_SHORT    6'h0f

// Register addresses
`define ADDR_NO_OPERATION 7'h00
`define ADDR_PIN_LEVELS   7'h06
`define ADDR_CHANNEL_ONE  7'h11
`define ADDR_CHANNEL_TWO  7'h12
`define ADDR_CHANNEL_THR  7'h13
`define ADDR_CHANNEL_FOU  7'h14
`define ADDR_CHANNEL_FIV  7'h15
`define ADDR_PACING       7'h1a
`define ADDR_BREATH_MAG   7'h1b
`define ADDR_BREATH_PHASE 7'h1c
`define ADDR_DETACH       7'h1d
`define ADDR_FRAME_START  7'h40
`define ADDR_FRAME_CHECK  7'h41

// Frame rate select codes
`define RATE_128K         2'h2

// Frame slot positions, one mask bit each
`define SLOT_PACING       4'h6
`define SLOT_BREATH_PHASE 4'h8
`define SLOT_COUNT        4'hc

// Timing
`define CLK_HZ            200000000
`define MCLK_BASE_HZ      1024000
`define HS_TICKS          2'h3

`endif
